// ### hw/aurx_top.sv
// asynchronous serial receiver with avalon register slave
`include "aurx_consts.svh"
module aurx_top
  import aurx_pkg::*;
(
  input  wire logic        mclk,                // system clock, 250 MHz
  input  wire logic        reset_n,             // async reset, active low
  input  wire logic [4:0]  avs_address,         // byte address
  input  wire logic        avs_read,            // read request
  input  wire logic        avs_write,           // write request
  input  wire logic [31:0] avs_writedata,       // write data
  input  wire logic [3:0]  avs_byteenable,      // byte lanes
  output logic [31:0]      avs_readdata,        // read data, registered
  output logic             avs_waitrequest,     // stall until answer
  input  wire logic        serial_input_pin_i,  // line from remote transmitter
  output logic             serial_input_pin_o,  // pin output value
  output logic             serial_input_pin_oe, // pin output enable
  input  wire logic        pin_direction_in,    // direction bit of input pin
  input  wire logic        pin_latch_in,        // port latch of input pin
  input  wire logic        pin_direction_out,   // direction bit of output pin
  input  wire logic        pin_latch_out,       // port latch of output pin
  input  wire logic        tx_line,             // transmitter line level
  output logic             serial_output_pin_o, // output pin value
  output logic             serial_output_pin_oe,// output pin enable
  output logic             rx_irq               // receive interrupt request
);
  // ---------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------
  logic [7:0]  rxsc_ctl_ff;      // serial_port_enable rx9 single_receive_enable continuous_receive_enable address_detect_enable bits
  logic [7:0]  txsc_ff;
  logic [7:0]  baud_ff;
  logic [7:0]  pie_ff;
  logic [7:0]  intc_ff;
  logic        ovr_ff;
  logic [31:0] rdata_ff;
  logic        ack_ff;
  aurx_state_t state_ff;
  logic [3:0]  phase_ff;
  logic [3:0]  bitn_ff;
  logic [8:0]  shift_ff;
  logic [2:0]  maj_ff;
  logic        line_prev_ff;

  logic       serial_port_enable;
  logic       continuous_receive_enable;
  logic       rx9;
  logic       address_detect_enable;
  logic       rx_on;
  logic       tick;
  logic       fifo_full;
  logic       fifo_empty;
  aurx_char_t fifo_head;
  aurx_char_t new_char;
  logic       pop;
  logic       push;
  logic       done;
  logic       keep;
  logic       rx_available_flag;
  logic       wr_hit;
  logic       rd_hit;
  logic       maj_bit;
  logic [3:0] nbits;
  logic [7:0] rxsc_rd;
  logic [7:0] pir_rd;
  logic [7:0] wbyte;

  assign serial_port_enable  = rxsc_ctl_ff[`AURX_RXSC_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable  = rxsc_ctl_ff[`AURX_RXSC_CONTINUOUS_RECEIVE_ENABLE];
  assign rx9   = rxsc_ctl_ff[`AURX_RXSC_RX9];
  assign address_detect_enable = rxsc_ctl_ff[`AURX_RXSC_ADDRESS_DETECT_ENABLE];
  assign rx_on = continuous_receive_enable && serial_port_enable && !txsc_ff[`AURX_TXSC_SYNC];
  assign nbits = rx9 ? 4'd9 : 4'd8;

  // ---------------------------------------------------------
  // pins
  // ---------------------------------------------------------
  // enabled port owns both pins; otherwise general-purpose latch drives
  assign serial_input_pin_oe  = serial_port_enable ? 1'b0 : !pin_direction_in;
  assign serial_input_pin_o   = serial_port_enable ? 1'b0 : pin_latch_in;
  assign serial_output_pin_oe = serial_port_enable ? 1'b1 : !pin_direction_out;
  assign serial_output_pin_o  = serial_port_enable ? tx_line : pin_latch_out;

  // ---------------------------------------------------------
  // bus handshake: one wait cycle, answer registered
  // ---------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  // writes land at the edge where waitrequest is low
  assign wr_hit = avs_write && ack_ff;
  assign rd_hit = avs_read && !ack_ff;
  assign wbyte  = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
    end
  end

  // ---------------------------------------------------------
  // control register writes (byte lane 0 only)
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rxsc_ctl_ff <= `AURX_RST_RXSC;
      txsc_ff     <= `AURX_RST_TXSC;
      baud_ff     <= `AURX_RST_BAUD;
      pie_ff      <= `AURX_RST_PIE;
      intc_ff     <= `AURX_RST_INTC;
    end else if (wr_hit && avs_byteenable[0]) begin
      unique case (avs_address)
        {1'b0, `AURX_OFS_RXSC}: rxsc_ctl_ff <= wbyte & 8'hF8;
        {1'b0, `AURX_OFS_TXSC}: txsc_ff     <= {wbyte[7:2], 1'b1, wbyte[0]};
        {1'b0, `AURX_OFS_BAUD}: baud_ff     <= wbyte;
        `AURX_OFS_PIE:          pie_ff      <= wbyte;
        `AURX_OFS_INTC:         intc_ff     <= wbyte;
        default:                ;  // flag register ignores writes
      endcase
    end
  end

  // ---------------------------------------------------------
  // read data mux and data pop
  // ---------------------------------------------------------
  assign rx_available_flag    = rx_on && !fifo_empty;
  assign pir_rd  = 8'(rx_available_flag) << `AURX_PIR_RX_AVAILABLE_FLAG;
  assign rxsc_rd = {rxsc_ctl_ff[7:3], fifo_head.framing_error_flag, ovr_ff, fifo_head.data[8]};
  assign pop     = avs_read && ack_ff && avs_address == {1'b0, `AURX_OFS_RXDATA};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_hit) begin
      unique case (avs_address)
        {1'b0, `AURX_OFS_RXSC}:   rdata_ff <= {24'h00_0000, rxsc_rd};
        {1'b0, `AURX_OFS_RXDATA}: rdata_ff <= {24'h00_0000, fifo_head.data[7:0]};
        {1'b0, `AURX_OFS_TXSC}:   rdata_ff <= {24'h00_0000, txsc_ff};
        {1'b0, `AURX_OFS_BAUD}:   rdata_ff <= {24'h00_0000, baud_ff};
        `AURX_OFS_PIE:            rdata_ff <= {24'h00_0000, pie_ff};
        `AURX_OFS_PIR:            rdata_ff <= {24'h00_0000, pir_rd};
        `AURX_OFS_INTC:           rdata_ff <= {24'h00_0000, intc_ff};
        default:                  rdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_ff;

  // interrupt gating
  assign rx_irq = rx_available_flag && pie_ff[`AURX_PIE_RX_INTERRUPT_ENABLE] && intc_ff[`AURX_INTC_PERIPHERAL_INTERRUPT_ENABLE]
                  && intc_ff[`AURX_INTC_GIE];

  // ---------------------------------------------------------
  // sampling tick
  // ---------------------------------------------------------
  aurx_tick_gen u_tick (
    .mclk    (mclk),
    .reset_n (reset_n),
    .run     (serial_port_enable),
    .divisor (baud_ff),
    .baud_high_speed_select    (txsc_ff[`AURX_TXSC_BAUD_HIGH_SPEED_SELECT]),
    .tick    (tick)
  );

  // ---------------------------------------------------------
  // majority window: three samples around bit centre
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      maj_ff <= 3'b111;
    end else if (tick && phase_ff >= `AURX_MAJ_FIRST && phase_ff <= `AURX_MAJ_LAST) begin
      maj_ff <= {maj_ff[1:0], serial_input_pin_i};
    end
  end
  // decided at the tick after the last window sample
  assign maj_bit = (maj_ff[0] & maj_ff[1]) | (maj_ff[1] & maj_ff[2])
                   | (maj_ff[0] & maj_ff[2]);

  // ---------------------------------------------------------
  // line edge detector for start hunting
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      line_prev_ff <= 1'b1;
    end else if (tick) begin
      line_prev_ff <= serial_input_pin_i;
    end
  end

  // ---------------------------------------------------------
  // recovery state machine, one step per tick
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= AURX_HUNT;
      phase_ff <= 4'd0;
      bitn_ff  <= 4'd0;
      shift_ff <= 9'h000;
    end else if (!rx_on || ovr_ff) begin
      state_ff <= AURX_HUNT;
      phase_ff <= 4'd0;
      bitn_ff  <= 4'd0;
    end else if (tick) begin
      unique case (state_ff)
        AURX_HUNT: begin
          phase_ff <= 4'd0;
          if (line_prev_ff && !serial_input_pin_i) begin
            state_ff <= AURX_START;
          end
        end
        AURX_START: begin
          phase_ff <= phase_ff + 4'd1;
          if (phase_ff == `AURX_HALF_BIT) begin
            if (serial_input_pin_i) begin
              state_ff <= AURX_HUNT;
            end else begin
              state_ff <= AURX_DATA;
              phase_ff <= 4'd0;
              bitn_ff  <= 4'd0;
            end
          end
        end
        AURX_DATA: begin
          phase_ff <= phase_ff + 4'd1;
          if (phase_ff == `AURX_FULL_BIT) begin
            // lsb arrives first, so shift in from the top
            shift_ff <= rx9 ? {maj_bit, shift_ff[8:1]} : {1'b0, maj_bit, shift_ff[7:1]};
            bitn_ff  <= bitn_ff + 4'd1;
            if (bitn_ff == nbits - 4'd1) begin
              state_ff <= AURX_STOP;
            end
          end
        end
        AURX_STOP: begin
          phase_ff <= phase_ff + 4'd1;
          if (phase_ff == `AURX_FULL_BIT) begin
            state_ff <= AURX_HUNT;
            phase_ff <= 4'd0;
          end
        end
        default: state_ff <= AURX_HUNT;
      endcase
    end
  end

  // ---------------------------------------------------------
  // character completion and overrun
  // ---------------------------------------------------------
  assign done = tick && rx_on && !ovr_ff && state_ff == AURX_STOP
                && phase_ff == `AURX_FULL_BIT;
  assign keep = !(address_detect_enable && rx9) || shift_ff[8];
  assign new_char.framing_error_flag = !maj_bit;
  assign new_char.data = shift_ff;
  assign push = done && keep && !fifo_full;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ovr_ff <= 1'b0;
    end else if (done && keep && fifo_full && !pop) begin
      ovr_ff <= 1'b1;
    end else if (!continuous_receive_enable || !serial_port_enable) begin
      ovr_ff <= 1'b0;
    end
  end

  aurx_fifo #(
    .DEPTH (2)
  ) u_fifo (
    .mclk    (mclk),
    .reset_n (reset_n),
    .flush   (!serial_port_enable),
    .push    (push || (done && keep && fifo_full && pop)),
    .wdata   (new_char),
    .pop     (pop),
    .head    (fifo_head),
    .full    (fifo_full),
    .empty   (fifo_empty)
  );
endmodule

// ### hw/aurx_consts.svh
// register offsets, field positions, reset values and timing counts of the receiver
`ifndef AURX_CONSTS_SVH
`define AURX_CONSTS_SVH
// -------------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------------
`define AURX_OFS_RXSC     4'h0
`define AURX_OFS_RXDATA   4'h4
`define AURX_OFS_TXSC     4'h8
`define AURX_OFS_BAUD     4'hC
// upper word holds both interrupt registers and the interrupt control copy
`define AURX_OFS_PIE      5'h10
`define AURX_OFS_PIR      5'h14
`define AURX_OFS_INTC     5'h18
// -------------------------------------------------------------------
// field positions
// -------------------------------------------------------------------
`define AURX_RXSC_SERIAL_PORT_ENABLE    7
`define AURX_RXSC_RX9     6
`define AURX_RXSC_SINGLE_RECEIVE_ENABLE    5
`define AURX_RXSC_CONTINUOUS_RECEIVE_ENABLE    4
`define AURX_RXSC_ADDRESS_DETECT_ENABLE   3
`define AURX_RXSC_FRAMING_ERROR_FLAG    2
`define AURX_RXSC_OVERRUN_ERROR_FLAG    1
`define AURX_RXSC_RX_NINTH_BIT    0
`define AURX_TXSC_SYNC    4
`define AURX_TXSC_BAUD_HIGH_SPEED_SELECT    2
`define AURX_PIE_RX_INTERRUPT_ENABLE     5
`define AURX_PIR_RX_AVAILABLE_FLAG     5
`define AURX_INTC_GIE     7
`define AURX_INTC_PERIPHERAL_INTERRUPT_ENABLE    6
// -------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------
`define AURX_RST_RXSC     8'h00
`define AURX_RST_TXSC     8'h02
`define AURX_RST_BAUD     8'h00
`define AURX_RST_PIE      8'h00
`define AURX_RST_INTC     8'h00
// -------------------------------------------------------------------
// timing counts in sampling ticks
// -------------------------------------------------------------------
`define AURX_OVERSAMPLE   5'd16
`define AURX_HALF_BIT     4'd7
`define AURX_FULL_BIT     4'd15
`define AURX_MAJ_FIRST    4'd12
`define AURX_MAJ_LAST     4'd14
`define AURX_BAUD_HIGH_SPEED_SELECT_SHIFT   2
`endif

// ### hw/aurx_pkg.sv
// types shared by the receiver modules
package aurx_pkg;
  // one received character as it sits in the fifo
  typedef struct packed {
    logic       framing_error_flag;
    logic [8:0] data;
  } aurx_char_t;

  // receive recovery states
  typedef enum logic [3:0] {
    AURX_HUNT  = 4'b0001,
    AURX_START = 4'b0010,
    AURX_DATA  = 4'b0100,
    AURX_STOP  = 4'b1000
  } aurx_state_t;
endpackage

// ### hw/aurx_tick_gen.sv
// sixteen-times sampling tick from the shared baud divisor
module aurx_tick_gen
  import aurx_pkg::*;
(
  input  wire logic       mclk,     // system clock
  input  wire logic       reset_n,  // async reset, active low
  input  wire logic       run,      // count while port is enabled
  input  wire logic [7:0] divisor,  // baud divisor value
  input  wire logic       baud_high_speed_select,     // high speed select
  output logic            tick      // one-cycle sampling strobe
);
  logic [9:0] cnt_ff;
  logic [9:0] limit;

  // divisor+1 clocks per tick at high speed, four times that otherwise
  assign limit = baud_high_speed_select ? {2'b00, divisor} : {divisor, 2'b11};

  // ---------------------------------------------------------
  // tick counter
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 10'h000;
    end else if (!run || cnt_ff >= limit) begin
      cnt_ff <= 10'h000;
    end else begin
      cnt_ff <= cnt_ff + 10'h001;
    end
  end

  assign tick = run && (cnt_ff >= limit);
endmodule

// ### hw/aurx_fifo.sv
// two-entry receive character store with registered head
module aurx_fifo
  import aurx_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic       mclk,     // system clock
  input  wire logic       reset_n,  // async reset, active low
  input  wire logic       flush,    // drop all entries
  input  wire logic       push,     // store one character
  input  wire aurx_char_t wdata,    // character to store
  input  wire logic       pop,      // remove oldest character
  output aurx_char_t      head,     // oldest character, registered
  output logic            full,     // no room left
  output logic            empty     // nothing stored
);
  initial begin
    if (DEPTH != 2) $error("aurx_fifo supports depth 2 only");
  end

  aurx_char_t slot_ff [DEPTH];
  logic [1:0] cnt_ff;

  assign full  = (cnt_ff == 2'd2);
  assign empty = (cnt_ff == 2'd0);
  assign head  = slot_ff[0];

  // ---------------------------------------------------------
  // fill count
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 2'd0;
    end else if (flush) begin
      cnt_ff <= 2'd0;
    end else begin
      // a push into a full store is only taken together with a pop
      cnt_ff <= cnt_ff + 2'(push && (!full || pop)) - 2'(pop && !empty);
    end
  end

  // ---------------------------------------------------------
  // shift store: slot 0 is always the oldest
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slot_ff[0] <= '0;
      slot_ff[1] <= '0;
    end else if (flush) begin
      slot_ff[0] <= '0;
      slot_ff[1] <= '0;
    end else if (pop && !empty) begin
      slot_ff[0] <= (cnt_ff == 2'd1) ? wdata : slot_ff[1];
      slot_ff[1] <= wdata;
      if (!(push && cnt_ff == 2'd1)) begin
        slot_ff[0] <= (cnt_ff == 2'd2) ? slot_ff[1] : '0;
      end
    end else if (push && !full) begin
      if (cnt_ff == 2'd0) begin
        slot_ff[0] <= wdata;
      end else begin
        slot_ff[1] <= wdata;
      end
    end
  end
endmodule

// ### sim/aurx_top_monitor.sv
// assertion checker for the receiver's bus, pins and interrupt
`include "aurx_consts.svh"
module aurx_top_monitor (
  input wire logic        mclk,                 // clock
  input wire logic        reset_n,              // reset
  input wire logic [4:0]  avs_address,          // address
  input wire logic        avs_read,             // read
  input wire logic        avs_write,            // write
  input wire logic [31:0] avs_writedata,        // wdata
  input wire logic [3:0]  avs_byteenable,       // lanes
  input wire logic [31:0] avs_readdata,         // rdata
  input wire logic        avs_waitrequest,      // stall
  input wire logic        serial_input_pin_o,   // rx pin out
  input wire logic        serial_input_pin_oe,  // rx pin oe
  input wire logic        pin_direction_in,     // rx dir
  input wire logic        pin_latch_in,         // rx latch
  input wire logic        tx_line,              // tx level
  input wire logic        serial_output_pin_o,  // tx pin out
  input wire logic        serial_output_pin_oe, // tx pin oe
  input wire logic        rx_irq                // irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic       wr_ok;
  logic       rd_ok;
  logic [7:0] rxsc_ff;
  logic [7:0] pie_ff;
  logic [7:0] intc_ff;
  // accepted transfers
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ok = avs_read && !avs_waitrequest;
  // shadow copies of the control registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rxsc_ff <= 8'h00;
      pie_ff  <= 8'h00;
      intc_ff <= 8'h00;
    end else if (wr_ok) begin
      if (avs_address == `AURX_OFS_RXSC) rxsc_ff <= avs_writedata[7:0];
      if (avs_address == `AURX_OFS_PIE) pie_ff <= avs_writedata[7:0];
      if (avs_address == `AURX_OFS_INTC) intc_ff <= avs_writedata[7:0];
    end
  end
  property p_wait_first;
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no stall in first cycle");
  property p_wait_second;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_second: assert property (p_wait_second) else $error("stall longer than one cycle");
  property p_upper_zero;
    rd_ok |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bytes not zero");
  property p_unmapped;
    rd_ok && avs_address == 5'h1C |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_in_pin;
    serial_input_pin_oe |-> !rxsc_ff[7] && !pin_direction_in
      && serial_input_pin_o == pin_latch_in;
  endproperty
  a_in_pin: assert property (p_in_pin) else $error("input pin driven wrongly");
  property p_out_pin;
    rxsc_ff[7] |-> serial_output_pin_oe && serial_output_pin_o == tx_line;
  endproperty
  a_out_pin: assert property (p_out_pin) else $error("output pin not forced");
  property p_irq_gate;
    rx_irq |-> rxsc_ff[7] && pie_ff[5] && intc_ff[7] && intc_ff[6];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without all enables");
  property p_flag_off;
    rd_ok && avs_address == `AURX_OFS_PIR && !rxsc_ff[7] |-> !avs_readdata[5];
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag set while disabled");
  property p_ovr_clear;
    rd_ok && avs_address == `AURX_OFS_RXSC && !rxsc_ff[4] |-> !avs_readdata[1];
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun kept after clear");
  property p_int_back;
    rd_ok && avs_address == `AURX_OFS_INTC |-> avs_readdata[7:6] == intc_ff[7:6];
  endproperty
  a_int_back: assert property (p_int_back) else $error("interrupt enables misread");
endmodule
bind aurx_top aurx_top_monitor u_mon (.mclk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .serial_input_pin_o,
  .serial_input_pin_oe, .pin_direction_in, .pin_latch_in, .tx_line, .serial_output_pin_o,
  .serial_output_pin_oe, .rx_irq);

// ### sim/aurx_line_model.sv
// remote serial transmitter driving the receive line
module aurx_line_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic mclk, // system clock
  output logic      line  // serial line, idle high
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // one frame: start low, data lsb first, then stop level
  task automatic send(input logic [8:0] d, input int nbits, input logic stop);
    int i;
    @(posedge mclk);
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge mclk);
    for (i = 0; i < nbits; i++) begin
      line <= d[i];
      repeat (BIT_CLKS) @(posedge mclk);
    end
    line <= stop;
    repeat (BIT_CLKS) @(posedge mclk);
    line <= 1'b1;
  endtask
  // short low pulse that ends before the start centre
  task automatic glitch;
    @(posedge mclk);
    line <= 1'b0;
    repeat (BIT_CLKS / 4) @(posedge mclk);
    line <= 1'b1;
    repeat (BIT_CLKS * 12) @(posedge mclk);
  endtask
endmodule

// ### sim/aurx_top_test.sv
// self-checking bench for the serial receiver
module aurx_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdq;
  logic [31:0] rdat;
  logic        wreq;
  logic        line;
  logic [4:0]  gp = 5'h00;
  logic        in_o, in_oe, out_o, out_oe, irq;
  logic        nine = 1'b0;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          seed = 47263;
  int          i;
  int          q[$];
  logic [4:0]  ra[7] = '{5'h00, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18, 5'h1C};
  logic [7:0]  rv[7] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  aurx_top u_dut (.mclk(mclk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdq),
    .avs_waitrequest(wreq), .serial_input_pin_i(line), .serial_input_pin_o(in_o),
    .serial_input_pin_oe(in_oe), .pin_direction_in(gp[0]), .pin_latch_in(gp[1]),
    .pin_direction_out(gp[2]), .pin_latch_out(gp[3]), .tx_line(gp[4]),
    .serial_output_pin_o(out_o), .serial_output_pin_oe(out_oe), .rx_irq(irq));
  aurx_line_model #(.BIT_CLKS(32)) u_line (.mclk(mclk), .line(line));
  // clock and run limit
  initial begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one bus transfer, held until the stall drops
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    logic ws;
    @(posedge mclk);
    adr <= a;
    wdat <= {24'h00_0000, d};
    wr <= w;
    rd <= !w;
    n = 0;
    // stall is looked at mid-cycle, so the edge that follows is the one it qualifies
    do begin
      @(negedge mclk);
      ws = wreq;
      n++;
      @(posedge mclk);
    end while (ws !== 1'b0 && n < 40);
    rdat = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) n_mismatch++;
  endtask
  task automatic flag_chk;
    bus(1'b0, 5'h14, 8'h00);
    chk(rdat, (q.size() > 0) ? 32'h0000_0020 : 32'h0000_0000);
  endtask
  task automatic irq_chk(input logic e);
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // frame on the line, model keeps what should be stored
  task automatic rx(input logic [8:0] d, input logic stop, input bit keep);
    u_line.send(d, nine ? 9 : 8, stop);
    repeat (4) @(posedge mclk);
    if (keep) q.push_back(int'({!stop, d}));
  endtask
  task automatic pop_chk;
    int e;
    e = q.pop_front();
    bus(1'b0, 5'h00, 8'h00);
    chk(rdat & 32'h0000_0005, {29'h0, e[9], 1'b0, e[8]});
    bus(1'b0, 5'h04, 8'h00);
    chk(rdat, {24'h00_0000, e[7:0]});
  endtask
  task automatic pins(input logic en);
    repeat (4) begin
      @(posedge mclk);
      gp <= 5'($random(seed));
      @(negedge mclk);
      if (en) chk({30'h0, in_oe, out_oe}, {30'h0, 1'b0, 1'b1});
      if (en) chk({31'h0, out_o}, {31'h0, gp[4]});
      else chk({30'h0, in_oe, in_o}, {30'h0, !gp[0], gp[1]});
    end
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    for (i = 0; i < 7; i++) begin
      bus(1'b0, ra[i], 8'h00);
      chk(rdat, {24'h00_0000, rv[i]});
    end
    pins(1'b0);
    bus(1'b1, 5'h0C, 8'h01);
    bus(1'b1, 5'h08, 8'h04);
    bus(1'b1, 5'h10, 8'h20);
    bus(1'b1, 5'h18, 8'hC0);
    bus(1'b1, 5'h00, 8'h90);
    pins(1'b1);
    $display("reset and pin test done");
    bus(1'b1, 5'h14, 8'hFF);
    flag_chk();
    u_line.glitch();
    flag_chk();
    irq_chk(1'b0);
    $display("glitch test done");
    rx(9'($random(seed) & 8'hFF), 1'b1, 1);
    rx(9'($random(seed) & 8'hFF), 1'b0, 1);
    flag_chk();
    irq_chk(1'b1);
    bus(1'b1, 5'h18, 8'h40);
    irq_chk(1'b0);
    flag_chk();
    pop_chk();
    pop_chk();
    flag_chk();
    bus(1'b1, 5'h18, 8'hC0);
    $display("fifo test done");
    for (i = 0; i < 4; i++) rx(9'($random(seed) & 8'hFF), 1'b1, i < 2);
    bus(1'b0, 5'h00, 8'h00);
    chk(rdat & 32'h0000_0002, 32'h0000_0002);
    pop_chk();
    pop_chk();
    flag_chk();
    bus(1'b1, 5'h00, 8'h80);
    bus(1'b0, 5'h00, 8'h00);
    chk(rdat & 32'h0000_0002, 32'h0000_0000);
    $display("overrun test done");
    nine = 1'b1;
    bus(1'b1, 5'h00, 8'hD8);
    rx(9'h0A5, 1'b1, 0);
    rx(9'h13C, 1'b1, 1);
    pop_chk();
    flag_chk();
    bus(1'b1, 5'h00, 8'hD0);
    rx(9'h05A, 1'b1, 1);
    pop_chk();
    rx(9'h1C3, 1'b1, 0);
    bus(1'b1, 5'h00, 8'h00);
    flag_chk();
    $display("nine bit test done");
    summarize();
  end
endmodule
